// File: hdl/ombp_pkg.sv
// package for the operating-mode and bus-port control block
// assumes one 10 MHz clock and an apb master on the same clock
// Notes on behaviour
// [RQ1] mode pins 100..111 select operating modes 4 to 7
// [RQ2] every mode runs the cpu in advanced mode, 16-Mbyte linear space
// [RQ3] mode 4: rom off, ports 1/a/b/c address, d/e data, f control
// [RQ4] mode 4: bus starts 16 bits, drops to 8 only if all areas 8-bit
// [RQ5] mode 5: rom off, ports 1/a/b/c address, d data (e joins when 16-bit), f control
// [RQ6] modes 5/6: start 8 bits, any 16-bit area widens, port e joins data
// [RQ7] mode 6: rom on, ports 1/a/b/c plain inputs after reset
// [RQ8] mode 6: a port pin drives address when its direction bit is 1
// [RQ9] mode 6: port d is data bus, part of port f bus control
// [RQ10] mode 7: rom on, external access blocked, all ports general i/o
// [RQ11] eight areas each hold a width setting, 8 or 16 bits
// [RQ12] after reset areas are basic 3-state, width follows the mode
// [RQ13] mode pins stay stable; decoded mode is fixed after reset release
package ombp_pkg;
  typedef enum logic [2:0] {
    OMBP_MODE_4 = 3'b100,
    OMBP_MODE_5 = 3'b101,
    OMBP_MODE_6 = 3'b110,
    OMBP_MODE_7 = 3'b111
  } ombp_mode_t;

  localparam logic [11:0] OMBP_ADDR_MODE   = 12'h000;
  localparam logic [11:0] OMBP_ADDR_WIDTH  = 12'h004;
  localparam logic [11:0] OMBP_ADDR_ACCESS = 12'h008;
  localparam logic [11:0] OMBP_ADDR_DDR    = 12'h00c;
  localparam logic [11:0] OMBP_ADDR_STATUS = 12'h010;

  localparam int          OMBP_AREAS       = 8;
  localparam int          OMBP_ADDR_PINS   = 24;
  localparam logic [7:0]  OMBP_WIDTH_RST16 = 8'h00;
  localparam logic [7:0]  OMBP_WIDTH_RST8  = 8'hff;
  localparam logic [7:0]  OMBP_ACCESS_RST  = 8'hff;
  localparam logic [23:0] OMBP_DDR_RST     = 24'h000000;
  localparam int          OMBP_SPACE_MBYTE = 16;
  localparam int          OMBP_ADV_BIT     = 0;
  localparam int          OMBP_ROM_BIT     = 1;
  localparam int          OMBP_EXT_BIT     = 2;
  localparam int          OMBP_BUS16_BIT   = 3;
  localparam int          OMBP_PE_BIT      = 4;
  localparam int          OMBP_PF_BIT      = 5;
  localparam int          OMBP_PD_BIT      = 6;
  localparam int          OMBP_VALID_BIT   = 7;
endpackage

// File: hdl/ombp_sync.sv
// two-flop synchroniser for the mode-select pins
// assumes the pins are asynchronous to clk_i
// no reset: the flops keep tracking the pins while reset is held, so the
// mode latched on the first edge after release is the strapped one
module ombp_sync
(
  input  wire logic       clk_i,   // system clock
  input  wire logic [2:0] d_i,     // raw pin levels
  output logic      [2:0] q_o      // synchronised levels
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;

  always_ff @(posedge clk_i)
  begin
    meta_reg <= d_i;
    sync_reg <= meta_reg;
  end

  assign q_o = sync_reg;
endmodule

// File: hdl/ombp_ctrl.sv
// operating-mode decode and port-function control with an apb register slave
// assumes mode pins are stable around reset and apb runs on clk_i
//
// Register access over APB and the register addresses were left to the implementer.
module ombp_ctrl
(
  input  wire logic        clk_i,              // 10 MHz system clock
  input  wire logic        reset_i,            // async reset, active high
  input  wire logic [2:0]  mode_select_pins_i, // mode pins from the board
  input  wire logic        psel_i,             // apb select
  input  wire logic        penable_i,          // apb enable
  input  wire logic        pwrite_i,           // apb direction
  input  wire logic [11:0] paddr_i,            // apb byte address
  input  wire logic [31:0] pwdata_i,           // apb write data
  output logic      [31:0] prdata_o,           // apb read data
  output logic             pready_o,           // apb ready
  output logic             pslverr_o,          // apb error
  output logic [2:0]       mode_o,             // decoded mode, 4..7
  output logic             advanced_o,         // cpu advanced mode, 16-Mbyte space
  output logic             rom_enable_o,       // on-chip rom enabled
  output logic             ext_enable_o,       // external space accessible
  output logic             bus16_o,            // external data bus is 16 bits
  output logic [23:0]      addr_out_en_o,      // ports 1/a/b/c pins drive address
  output logic             data_lo_en_o,       // port d is the data bus
  output logic             data_hi_en_o,       // port e is upper data bus
  output logic             ctrl_en_o           // port f carries bus control
);
  logic [2:0]       pins_sync;
  logic             mode_valid_reg;
  ombp_pkg::ombp_mode_t mode_reg;
  logic [7:0]       area_width_select_reg;
  logic [7:0]       access3_reg;
  logic [23:0]      ddr_reg;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             rom_reg;
  logic             ext_reg;
  logic             bus16_reg;
  logic [23:0]      addr_en_reg;
  logic             dlo_reg;
  logic             dhi_reg;
  logic             ctl_reg;

  ombp_sync u_sync
  (
    .clk_i   (clk_i),
    .d_i     (mode_select_pins_i),
    .q_o     (pins_sync)
  );

  // reads the pin code as a mode; codes below 4 are not legal modes
  function automatic ombp_pkg::ombp_mode_t pin_mode(input logic [2:0] p);
    unique case (p)
      3'b100:  pin_mode = ombp_pkg::OMBP_MODE_4;
      3'b101:  pin_mode = ombp_pkg::OMBP_MODE_5;
      3'b110:  pin_mode = ombp_pkg::OMBP_MODE_6;
      3'b111:  pin_mode = ombp_pkg::OMBP_MODE_7;
      default: pin_mode = ombp_pkg::OMBP_MODE_7;
    endcase
  endfunction

  // latched once after release: later pin moves are ignored on purpose
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode_valid_reg <= 1'b0;
      mode_reg       <= ombp_pkg::OMBP_MODE_7;
    end
    else if (!mode_valid_reg)
    begin
      mode_valid_reg <= 1'b1;                    // [RQ13]
      mode_reg       <= pin_mode(pins_sync);     // [RQ1]
    end
  end

  wire is_m4 = (mode_reg == ombp_pkg::OMBP_MODE_4);
  wire is_m5 = (mode_reg == ombp_pkg::OMBP_MODE_5);
  wire is_m6 = (mode_reg == ombp_pkg::OMBP_MODE_6);
  wire is_m7 = (mode_reg == ombp_pkg::OMBP_MODE_7);

  // apb decode: single-cycle access, pready high in every access phase
  wire       acc     = psel_i && penable_i;
  wire       wr      = acc && pwrite_i;
  wire       hit_mod = (paddr_i == ombp_pkg::OMBP_ADDR_MODE);
  wire       hit_wid = (paddr_i == ombp_pkg::OMBP_ADDR_WIDTH);
  wire       hit_acc = (paddr_i == ombp_pkg::OMBP_ADDR_ACCESS);
  wire       hit_ddr = (paddr_i == ombp_pkg::OMBP_ADDR_DDR);
  wire       hit_sts = (paddr_i == ombp_pkg::OMBP_ADDR_STATUS);
  wire       mapped  = hit_mod | hit_wid | hit_acc | hit_ddr | hit_sts;
  wire       ro_wr   = wr && (hit_mod || hit_sts);
  wire       setup   = psel_i && !penable_i;

  // width reset value depends on the mode, so it loads when the mode latches
  wire [7:0] width_init = is_m4 ? ombp_pkg::OMBP_WIDTH_RST16 : ombp_pkg::OMBP_WIDTH_RST8;
  wire       first     = !mode_valid_reg;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      area_width_select_reg <= ombp_pkg::OMBP_WIDTH_RST8;
      access3_reg           <= ombp_pkg::OMBP_ACCESS_RST;     // [RQ12]
      ddr_reg               <= ombp_pkg::OMBP_DDR_RST;
    end
    else
    begin
      if (mode_valid_reg && wr && hit_wid)
        area_width_select_reg <= pwdata_i[7:0];               // [RQ11]
      else if (first)
        area_width_select_reg <= (pin_mode(pins_sync) == ombp_pkg::OMBP_MODE_4) ?
                                 ombp_pkg::OMBP_WIDTH_RST16 :
                                 ombp_pkg::OMBP_WIDTH_RST8;   // [RQ12]
      if (wr && hit_acc)
        access3_reg <= pwdata_i[7:0];
      if (wr && hit_ddr)
        ddr_reg <= pwdata_i[23:0];
    end
  end

  // bit set = 8-bit area; mode 4 narrows only when all are 8-bit
  wire all8  = &area_width_select_reg;                        // [RQ4]
  wire any16 = ~&area_width_select_reg;                       // [RQ6]

  wire       rom_next  = is_m6 | is_m7;                       // [RQ3] [RQ5] [RQ7] [RQ10]
  wire       ext_next  = !is_m7;                              // [RQ10]
  wire       b16_next  = is_m4 ? !all8 : ((is_m5 | is_m6) && any16);
  wire       dlo_next  = !is_m7;                              // [RQ9]
  wire       dhi_next  = !is_m7 && b16_next;                  // [RQ3] [RQ6]
  wire       ctl_next  = !is_m7;                              // [RQ9]
  wire [23:0] aen_next = (is_m4 | is_m5) ? {ombp_pkg::OMBP_ADDR_PINS{1'b1}} :
                         is_m6 ? ddr_reg : 24'h000000;        // [RQ7] [RQ8]

  wire [7:0] status = {mode_valid_reg, ctl_reg, dhi_reg, dlo_reg,
                       bus16_reg, ext_reg, rom_reg, 1'b1};    // [RQ2]

  wire [31:0] rd_mux = hit_mod ? {29'h0, mode_reg} :
                       hit_wid ? {24'h0, area_width_select_reg} :
                       hit_acc ? {24'h0, access3_reg} :
                       hit_ddr ? {8'h0, ddr_reg} :
                       hit_sts ? {24'h0, status} : 32'h0;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && (!mapped || (pwrite_i && (hit_mod || hit_sts)));
      prdata_reg  <= (setup && !pwrite_i) ? rd_mux : prdata_reg;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rom_reg     <= 1'b0;
      ext_reg     <= 1'b0;
      bus16_reg   <= 1'b0;
      dlo_reg     <= 1'b0;
      dhi_reg     <= 1'b0;
      ctl_reg     <= 1'b0;
      addr_en_reg <= 24'h000000;
    end
    else
    begin
      rom_reg     <= mode_valid_reg && rom_next;
      ext_reg     <= mode_valid_reg && ext_next;
      bus16_reg   <= mode_valid_reg && b16_next;               // [RQ4] [RQ6]
      dlo_reg     <= mode_valid_reg && dlo_next;               // [RQ3] [RQ5]
      dhi_reg     <= mode_valid_reg && dhi_next;
      ctl_reg     <= mode_valid_reg && ctl_next;
      addr_en_reg <= mode_valid_reg ? aen_next : 24'h000000;   // [RQ3] [RQ5]
    end
  end

  assign prdata_o      = prdata_reg;
  assign pready_o      = pready_reg;
  assign pslverr_o     = pslverr_reg;
  assign mode_o        = mode_reg;
  assign advanced_o    = 1'b1;                                 // [RQ2]
  assign rom_enable_o  = rom_reg;
  assign ext_enable_o  = ext_reg;
  assign bus16_o       = bus16_reg;
  assign addr_out_en_o = addr_en_reg;
  assign data_lo_en_o  = dlo_reg;
  assign data_hi_en_o  = dhi_reg;
  assign ctrl_en_o     = ctl_reg;

  // ro_wr is not used by pslverr; kept named for the err_c cover below
  mode_fixed_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $past(mode_valid_reg) |-> $stable(mode_reg))
    else $error("mode changed after latch"); // [RQ13]
  m7_noext_a: assert property (@(posedge clk_i) disable iff (reset_i)
    is_m7 && $past(is_m7) |-> !ext_enable_o && addr_out_en_o == 24'h0 && !ctrl_en_o)
    else $error("mode 7 drives external bus"); // [RQ10]
  rom_mode_a: assert property (@(posedge clk_i) disable iff (reset_i)
    mode_valid_reg && $past(mode_valid_reg) |-> rom_enable_o == (is_m6 || is_m7))
    else $error("rom enable wrong for mode"); // [RQ3]
  m4_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
    mode_valid_reg && is_m4 |=> bus16_o == !(&$past(area_width_select_reg)))
    else $error("mode 4 width wrong"); // [RQ4]
  m56_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
    mode_valid_reg && (is_m5 || is_m6) |=>
    bus16_o == !(&$past(area_width_select_reg)) && data_hi_en_o == bus16_o)
    else $error("mode 5/6 width wrong"); // [RQ6]
  m6_ddr_a: assert property (@(posedge clk_i) disable iff (reset_i)
    mode_valid_reg && is_m6 |=> addr_out_en_o == $past(ddr_reg))
    else $error("mode 6 address pins not from ddr"); // [RQ8]
  m45_addr_a: assert property (@(posedge clk_i) disable iff (reset_i)
    mode_valid_reg && (is_m4 || is_m5) |=> &addr_out_en_o && data_lo_en_o && ctrl_en_o)
    else $error("address bus not enabled"); // [RQ5]
  apb_ready_a: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("pready not one cycle"); // apb handshake; no RQ item covers it
  width_init_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(mode_valid_reg) |-> area_width_select_reg == width_init)
    else $error("width reset not per mode"); // [RQ12]
  adv_a: assert property (@(posedge clk_i) disable iff (reset_i) advanced_o)
    else $error("advanced mode lost"); // [RQ2]
  m6_init_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(mode_valid_reg) && is_m6 |=> addr_out_en_o == 24'h0)
    else $error("mode 6 ports not inputs after reset"); // [RQ7]

  wide_c: cover property (@(posedge clk_i) disable iff (reset_i) is_m5 ##1 $rose(bus16_o));
  narrow_c: cover property (@(posedge clk_i) disable iff (reset_i) is_m4 ##1 $fell(bus16_o));
  ddr_c: cover property (@(posedge clk_i) disable iff (reset_i) is_m6 && |addr_out_en_o);
  err_c: cover property (@(posedge clk_i) disable iff (reset_i) ro_wr ##1 pslverr_o);
endmodule

// File: bench/ombp_board.sv
// board-side model: strap resistors on the mode-select pins
// assumes the bench changes the strap code only while reset is held
module ombp_board
(
  input  wire logic [2:0] code_i, // strap code chosen by the bench
  output logic      [2:0] pins_o  // levels seen on the mode pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // straps are passive, so the level stays put between resets
  assign pins_o = code_i;
endmodule

// File: bench/operating_mode_bus_port_control_tb_top.sv
// bench top: one reset per strap code, apb traffic, port-function checks
// assumes the design answers apb with one access phase and no interrupts
module operating_mode_bus_port_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i     = 1'b0;
  logic        reset_i   = 1'b1;
  logic [2:0]  code      = 3'b100;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0;
  logic [2:0]  pins;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [2:0]  mode_o;
  logic        advanced_o;
  logic        rom_o;
  logic        ext_o;
  logic        bus16_o;
  logic [23:0] addr_en_o;
  logic        lo_o;
  logic        hi_o;
  logic        ctrl_o;
  int          n_fail      = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          seed        = 67;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  w;
  logic [23:0] ddr;
  logic [2:0]  m;

  ombp_board u_board (.code_i(code), .pins_o(pins));
  ombp_ctrl u_dut (.clk_i(clk_i), .reset_i(reset_i), .mode_select_pins_i(pins),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mode_o(mode_o), .advanced_o(advanced_o), .rom_enable_o(rom_o), .ext_enable_o(ext_o),
    .bus16_o(bus16_o), .addr_out_en_o(addr_en_o), .data_lo_en_o(lo_o),
    .data_hi_en_o(hi_o), .ctrl_en_o(ctrl_o));

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // whole run is about 625 cycles; the ceiling leaves wide margin
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until pready is sampled high, then releases it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  function automatic logic [23:0] exp_addr(input logic [2:0] md, input logic [23:0] dr);
    if (md == 3'b110)
      return dr;
    return (md == 3'b111) ? 24'h000000 : 24'hffffff;
  endfunction

  task automatic check_ports();
    logic ext;
    ext = (m != 3'b111);
    chk(mode_o, m);
    chk(advanced_o, 1'b1);
    chk(rom_o, m[1]);
    chk(ext_o, ext);
    chk(addr_en_o, exp_addr(m, ddr));
    chk(lo_o, ext);
    chk(ctrl_o, ext);
    chk(hi_o, ext && w != 8'hff);
    if (ext)
      chk(bus16_o, w != 8'hff);
    apb(1'b0, ombp_pkg::OMBP_ADDR_STATUS, 32'h0);
    chk(rd[2:0], {ext, m[1], 1'b1});
  endtask

  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      // an undefined strap code falls back to single-chip operation
      m = (i == 4) ? 3'b111 : 3'b100 + i[2:0];
      @(posedge clk_i);
      reset_i <= 1'b1;
      code    <= (i == 4) ? 3'b011 : m;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      w = (m == 3'b100) ? 8'h00 : 8'hff;
      ddr = 24'h000000;
      check_ports();
      apb(1'b0, ombp_pkg::OMBP_ADDR_WIDTH, 32'h0);
      chk(rd[7:0], w);
      apb(1'b0, ombp_pkg::OMBP_ADDR_ACCESS, 32'h0);
      chk(rd[7:0], 8'hff);
      apb(1'b0, ombp_pkg::OMBP_ADDR_MODE, 32'h0);
      chk(rd[2:0], m);
      apb(1'b1, ombp_pkg::OMBP_ADDR_MODE, 32'h5);
      chk(err, 1'b1);
      apb(1'b0, 12'h014, 32'h0);
      chk(err, 1'b1);
      for (int j = 0; j < 7; j++)
      begin
        // corners first: all narrow, one wide area, all wide, then random
        w = (j == 0) ? 8'hff : (j == 1) ? 8'h7f : (j == 2) ? 8'h00 : 8'($random(seed));
        ddr = (j == 0) ? 24'hffffff : 24'($random(seed));
        apb(1'b1, ombp_pkg::OMBP_ADDR_WIDTH, {24'h0, w});
        apb(1'b1, ombp_pkg::OMBP_ADDR_DDR, {8'h0, ddr});
        @(posedge clk_i);
        #1;
        check_ports();
        apb(1'b0, ombp_pkg::OMBP_ADDR_WIDTH, 32'h0);
        chk(rd[7:0], w);
      end
    end
    report_and_stop();
  end
endmodule
